/* File: rtl/ssp_frames.sv */
// Purpose: Master frame engine of a synchronous serial port (SPI and half-duplex command format).
// Assumes: Inputs synchronous to sys_clk; tx/rx words move by valid/ready streams.
// Notes:   Slave mode only sets the pads; no slave shifting is done here.
//
// What this block does
// - SPI polarity high idles clock high
// - Clock pad enabled as master, off as slave
// - Start: frame select low; transmit driven only in command format
// - First-edge capture: data, then clock edges
// - Single word: select rises half a period after the last edge, a full period with second-edge capture
// - First-edge capture pulses select between words
// - Second-edge capture: data and clock together
// - Second-edge capture keeps select low between words
// - Command frame: 8 out, 4-16 back
// - Command format idles clock low
// - Select fall loads and drives command MSB
// - Select low whole frame, receive idle
// - Reply bits sampled on rising clock
// - Select rise stores received command reply
// - Continuous command frames chain without select rise
// - Bit rate: clock over prescale times one plus rate
// - Format field: 0 SPI, 2 command
// - Control 0 field layout as packed
// - Words 4 to 16 bits, MSB first
module ssp_frames (
    input  wire logic              sys_clk,           // system clock, 250 MHz
    input  wire logic              rst_n,             // synchronous reset
    input  wire logic              port_enable,       // port enable
    input  wire logic              slave_mode_sel,    // 1 selects slave
    input  wire logic              slave_out_disable, // slave keeps transmit pad off
    input  wire ssp_pkg::ssp_cfg_s control_reg_0,     // rate, phase, polarity, format, size
    input  wire logic [7:0]        prescale_divisor,  // even divisor 2..254
    input  wire logic              tx_valid,          // transmit word offered
    output logic                   tx_ready,          // transmit word taken
    input  wire logic [15:0]       tx_data,           // transmit word, right aligned
    output logic                   rx_valid,          // received word waiting
    input  wire logic              rx_ready,          // receiver takes word
    output logic [15:0]            rx_data,           // received word, right aligned
    input  wire logic              serial_clock_pin_in, // clock pad level
    input  wire logic              frame_select_pin_in, // select pad level
    input  wire logic              serial_in_pin,     // receive data pad
    output ssp_pkg::ssp_pins_s     pins               // driven pad levels and enables
);

    // ****************************************
    // Configuration capture
    // ****************************************
    ssp_pkg::ssp_cfg_s   cfg_r;
    logic [7:0]          presc_r;
    logic                en_r;
    ssp_pkg::ssp_state_e st_r, st_nxt;
    logic [15:0]         div_r;
    logic [5:0]          t_r;
    logic                sclk_r;
    logic [15:0]         tx_sh_r;
    logic [15:0]         rx_sh_r;
    logic [15:0]         rx_mem_r [0:ssp_pkg::RX_DEPTH-1];
    logic                wr_r;
    logic                rd_r;
    logic [1:0]          cnt_r;

    function automatic logic [4:0] word_len(input logic [3:0] code);
        word_len = (code < ssp_pkg::SIZE_MIN_CODE) ? ssp_pkg::MIN_BITS : {1'b0, code} + 5'h01;
    endfunction : word_len

    wire        en_rise   = port_enable && !en_r;
    wire [4:0]  wbits     = word_len(cfg_r.word_size_sel);
    wire        is_cmd    = cfg_r.frame_format_sel == ssp_pkg::FMT_CMD;
    wire        fmt_ok    = is_cmd || cfg_r.frame_format_sel == ssp_pkg::FMT_SPI;
    wire [4:0]  periods   = is_cmd ? wbits + ssp_pkg::CMD_BITS + ssp_pkg::WAIT_BITS : wbits;
    wire [5:0]  last_edge = {periods, 1'b0};
    wire        cpha      = cfg_r.clock_phase && !is_cmd;
    wire        idle_clk  = cfg_r.clock_polarity && !is_cmd;
    wire [15:0] half_raw  = presc_r[7:1] * ({8'h00, cfg_r.rate_factor} + 16'h0001);
    wire [15:0] half_cnt  = (half_raw == 16'h0000) ? 16'h0001 : half_raw;
    wire        tick      = div_r == half_cnt - 16'h0001;
    wire [5:0]  tn        = t_r + 6'h01;

    // ****************************************
    // Edge decoding
    // ****************************************
    wire in_shift = st_r == ssp_pkg::ST_SHIFT;
    wire edge_now = in_shift && tick && t_r != last_edge;
    wire at_end   = in_shift && tick && t_r == last_edge;
    wire cap_edge = cpha ? !tn[0] : tn[0];
    wire capture  = edge_now && cap_edge && (!is_cmd || tn >= ssp_pkg::CAP_FIRST_EDGE);
    wire launch   = edge_now && (cpha ? (tn[0] && tn != 6'h01) : !tn[0]);
    wire mw_wrap  = edge_now && is_cmd && tn == last_edge;
    wire more     = en_r && fmt_ok && tx_valid && cnt_r == 2'h0;
    wire start    = st_r == ssp_pkg::ST_IDLE && en_r && fmt_ok && tx_valid
                    && cnt_r != 2'(ssp_pkg::RX_DEPTH);
    wire reload   = (mw_wrap && more) || (at_end && cpha && more);
    wire tx_pop   = start || reload;
    wire rx_push  = (mw_wrap && more)
                    || (st_r == ssp_pkg::ST_TAIL && tick && is_cmd)
                    || (at_end && !is_cmd);
    wire rx_pop   = rx_valid && rx_ready;
    wire toggle   = (st_r == ssp_pkg::ST_START && tick && cpha) || edge_now
                    || (at_end && reload);
    wire [4:0]  pad_sh   = ssp_pkg::MAX_BITS - wbits;
    wire [15:0] tx_load  = is_cmd ? {tx_data[7:0], 8'h00} : tx_data << pad_sh;
    wire [15:0] rx_mask  = 16'hFFFF >> pad_sh;
    wire        sel_low  = st_r == ssp_pkg::ST_START || in_shift || st_r == ssp_pkg::ST_TAIL;
    wire        drive_tx = in_shift || (st_r == ssp_pkg::ST_START && is_cmd);

    assign tx_ready = tx_pop;
    assign rx_valid = cnt_r != 2'h0;
    assign rx_data  = rx_mem_r[rd_r];

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ssp_pkg::ST_IDLE: begin
                if (start) begin
                    st_nxt = ssp_pkg::ST_START;
                end
            end
            ssp_pkg::ST_START: begin
                if (tick) begin
                    st_nxt = ssp_pkg::ST_SHIFT;
                end
            end
            ssp_pkg::ST_SHIFT: begin
                if (at_end) begin
                    st_nxt = cpha ? (more ? ssp_pkg::ST_SHIFT : ssp_pkg::ST_TAIL)
                                  : ssp_pkg::ST_GAP;
                end else if (mw_wrap && !more) begin
                    st_nxt = ssp_pkg::ST_TAIL;
                end
            end
            ssp_pkg::ST_TAIL: begin
                if (tick) begin
                    st_nxt = ssp_pkg::ST_IDLE;
                end
            end
            ssp_pkg::ST_GAP: begin
                if (tick) begin
                    st_nxt = ssp_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = ssp_pkg::ST_IDLE;
            end
        endcase
        if (!en_r) begin
            st_nxt = ssp_pkg::ST_IDLE;
        end
    end

    // Settings are frozen while enabled so a live frame never changes shape.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            en_r    <= 1'b0;
            cfg_r   <= ssp_pkg::CFG_RESET;
            presc_r <= 8'h00;
        end else begin
            en_r <= port_enable;
            if (en_rise) begin
                cfg_r   <= control_reg_0;
                presc_r <= prescale_divisor;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r  <= ssp_pkg::ST_IDLE;
            div_r <= 16'h0000;
        end else begin
            st_r  <= st_nxt;
            div_r <= (st_r == ssp_pkg::ST_IDLE || tick) ? 16'h0000 : div_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            t_r    <= 6'h00;
            sclk_r <= 1'b0;
        end else begin
            if (start || (mw_wrap && more)) begin
                t_r <= 6'h00;
            end else if ((st_r == ssp_pkg::ST_START && tick) || (at_end && reload)) begin
                t_r <= cpha ? 6'h01 : 6'h00;
            end else if (edge_now) begin
                t_r <= tn;
            end
            if (st_r == ssp_pkg::ST_IDLE || !en_r) begin
                sclk_r <= idle_clk;
            end else if (toggle) begin
                sclk_r <= !sclk_r;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_sh_r <= 16'h0000;
            rx_sh_r <= 16'h0000;
        end else begin
            if (tx_pop) begin
                tx_sh_r <= tx_load;
            end else if (launch) begin
                tx_sh_r <= {tx_sh_r[14:0], 1'b0};
            end
            if (capture) begin
                rx_sh_r <= {rx_sh_r[14:0], serial_in_pin};
            end
        end
    end

    // ****************************************
    // Two-entry receive buffer
    // ****************************************
    // A full buffer holds off the next word rather than dropping one.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_r  <= 1'b0;
            rd_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (rx_push) begin
                rx_mem_r[wr_r] <= rx_sh_r & rx_mask;
                wr_r           <= !wr_r;
            end
            if (rx_pop) begin
                rd_r <= !rd_r;
            end
            cnt_r <= cnt_r + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end

    // ****************************************
    // Pads
    // ****************************************
    assign pins.clk_o  = sclk_r;
    assign pins.clk_oe = !slave_mode_sel;
    assign pins.fss_o  = !sel_low;
    assign pins.fss_oe = !slave_mode_sel;
    assign pins.tx_o   = drive_tx && tx_sh_r[15];
    assign pins.tx_oe  = !slave_mode_sel || !slave_out_disable;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_word_end_first;
        at_end && !cpha;
    endsequence

    sequence s_select_high;
        pins.fss_o && !tx_pop;
    endsequence

    a_idle_levels: assert property (st_r == ssp_pkg::ST_IDLE && $past(st_r == ssp_pkg::ST_IDLE)
        && $stable(cfg_r) |-> pins.fss_o && !pins.tx_o && pins.clk_o == idle_clk)
        else $error("idle line levels wrong");
    a_clock_pad: assert property (pins.clk_oe == !slave_mode_sel)
        else $error("clock pad enable wrong");
    a_start_select: assert property (start |=> !pins.fss_o ##0 st_r == ssp_pkg::ST_START)
        else $error("start did not lower select");
    a_single_end: assert property (s_word_end_first |=> s_select_high)
        else $error("select not high after word");
    a_keep_low: assert property (at_end && cpha && more |=> !pins.fss_o ##0 in_shift)
        else $error("select left low state between words");
    a_cmd_msb: assert property (start && is_cmd |=> pins.tx_o == $past(tx_data[7]))
        else $error("command msb not driven");
    a_cmd_frame: assert property (in_shift && is_cmd |-> !pins.fss_o && periods > 5'h0C)
        else $error("command frame shape wrong");
    a_cmd_store: assert property (st_r == ssp_pkg::ST_TAIL && tick && is_cmd
        |-> rx_push ##1 pins.fss_o)
        else $error("reply not stored at select rise");
    a_no_early_cap: assert property (is_cmd && capture |-> t_r >= 6'h12)
        else $error("sample during command");
    a_disable_idle: assert property (!en_r |=> st_r == ssp_pkg::ST_IDLE)
        else $error("disabled port not idle");
    a_cfg_frozen: assert property (en_r && $past(en_r) |-> $stable(cfg_r))
        else $error("settings changed while enabled");
    a_buf_space: assert property (rx_push |-> cnt_r != 2'h2 || rx_pop)
        else $error("receive buffer overrun");

endmodule : ssp_frames

/* File: rtl/ssp_pkg.sv */
// Purpose: Shared constants and types for the synchronous serial port frame logic.
// Assumes: One 250 MHz system clock; control fields arrive as plain ports.
// Notes:   Control word layout matches control_reg_0 bit for bit.
package ssp_pkg;

    // ****************************************
    // Frame formats and frame geometry
    // ****************************************
    localparam logic [1:0] FMT_SPI       = 2'h0;
    localparam logic [1:0] FMT_PULSE     = 2'h1;
    localparam logic [1:0] FMT_CMD       = 2'h2;
    localparam logic [1:0] FMT_RESERVED  = 2'h3;
    localparam logic [4:0] CMD_BITS      = 5'h08;
    localparam logic [4:0] WAIT_BITS     = 5'h01;
    localparam logic [4:0] MIN_BITS      = 5'h04;
    localparam logic [4:0] MAX_BITS      = 5'h10;
    localparam logic [3:0] SIZE_MIN_CODE = 4'h3;
    // First edge on which a reply bit is sampled: rising edge of period 10.
    localparam logic [5:0] CAP_FIRST_EDGE = 6'h13;
    localparam int         SYS_CLK_NS    = 4;
    localparam int         RX_DEPTH      = 2;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] rate_factor;      // bits 15:8
        logic       clock_phase;      // bit 7
        logic       clock_polarity;   // bit 6
        logic [1:0] frame_format_sel; // bits 5:4
        logic [3:0] word_size_sel;    // bits 3:0
    } ssp_cfg_s;

    localparam ssp_cfg_s CFG_RESET = 16'h0000;

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic fss_o;
        logic fss_oe;
        logic tx_o;
        logic tx_oe;
    } ssp_pins_s;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_SHIFT = 5'h04,
        ST_TAIL  = 5'h08,
        ST_GAP   = 5'h10
    } ssp_state_e;

endpackage : ssp_pkg

/* File: dv/ssp_slave_model.sv */
// Purpose: Behavioural serial slave on the far side of the frame engine.
// Assumes: Clock polarity high in SPI modes; replies queued by the bench in rq.
// Notes:   A released receive line flips level so a stale bit never passes.
module ssp_slave_model (
    input  wire logic       sclk,    // serial clock at the pad
    input  wire logic       fss_n,   // frame select, low while selected
    input  wire logic       mosi,    // data from the port
    input  wire logic [1:0] mode,    // 0 first-edge, 1 second-edge, 2 command
    input  wire logic [4:0] wbits,   // word length in bits
    output logic            miso,    // data back to the port
    output logic [15:0]     got,     // last word captured
    output int              got_cnt  // words captured so far
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rq[$];
    logic [15:0] rep;
    logic [15:0] sh;
    int          cnt;
    int          k;
    initial begin
        miso = 1'b0;
        got = 16'h0000;
        got_cnt = 0;
        cnt = 0;
        k = 0;
        sh = 16'h0000;
        rep = 16'h0000;
    end
    task automatic drive();
        if (k == 0) rep = (rq.size() != 0) ? rq.pop_front() : 16'h0000;
        if (k < wbits) begin
            miso = rep[wbits-1-k];
            k++;
        end else miso = ~miso;
    endtask : drive
    task automatic take(input int n);
        sh = {sh[14:0], mosi};
        cnt++;
        if (cnt == n) begin
            got = sh;
            got_cnt++;
        end
    endtask : take
    always @(negedge fss_n) begin
        cnt = 0;
        k = 0;
        sh = 16'h0000;
        if (mode == 2'h0) drive();
        else miso = ~miso;
    end
    always @(posedge fss_n) miso = ~miso;
    always @(posedge sclk) if (!fss_n) begin
        if (mode == 2'h0) drive();
        else if (mode == 2'h1) begin
            take(wbits);
            if (cnt == wbits) begin
                cnt = 0;
                k = 0;
                sh = 16'h0000;
            end
        end else if (cnt < 8) take(8);
        else begin
            cnt++;
            if (cnt == 9 + wbits) begin
                cnt = 0;
                k = 0;
                sh = 16'h0000;
            end
        end
    end
    always @(negedge sclk) if (!fss_n) begin
        if (mode == 2'h0) take(wbits);
        else if (mode == 2'h1 || cnt >= 9) drive();
        else miso = ~miso;
    end
endmodule : ssp_slave_model

/* File: dv/tb_ssp_frames.sv */
// Purpose: Self-checking bench for the serial port frame engine.
// Assumes: Slave model on the pads; a half serial period is (prescale/2)*(1+rate) clocks.
// Notes:   Expected words and frame lengths are queued by the driver, checked by watchers.
module tb_ssp_frames;
    timeunit 1ns;
    timeprecision 1ps;
    logic               sys_clk, rst_n, port_enable, slave_mode_sel, slave_out_disable;
    ssp_pkg::ssp_cfg_s  cfg;
    ssp_pkg::ssp_pins_s pins;
    logic [7:0]         pre;
    logic               tx_valid, tx_ready, rx_valid, rx_ready, sin;
    logic [15:0]        tx_data, rx_data, got;
    logic [1:0]         mode;
    int                 got_cnt, miscompares, num_checks, seed, taken, len;
    logic [15:0]        exp_rx[$], exp_tx[$];
    int                 exp_len[$];
    localparam logic [15:0] TCFG [6] = '{16'h0047, 16'h02CF, 16'h0023, 16'h012F, 16'h0043, 16'h01C9};
    localparam int          NW [6]   = '{3, 3, 2, 1, 3, 1};
    assign mode = (cfg.frame_format_sel == ssp_pkg::FMT_CMD) ? 2'h2 : {1'b0, cfg.clock_phase};
    ssp_frames ssp_frames_inst (.sys_clk(sys_clk), .rst_n(rst_n), .port_enable(port_enable),
        .slave_mode_sel(slave_mode_sel), .slave_out_disable(slave_out_disable),
        .control_reg_0(cfg), .prescale_divisor(pre), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .serial_clock_pin_in(pins.clk_o), .frame_select_pin_in(pins.fss_o),
        .serial_in_pin(sin), .pins(pins));
    ssp_slave_model ssp_slave_model_inst (.sclk(pins.clk_o), .fss_n(pins.fss_o),
        .mosi(pins.tx_o), .mode(mode), .wbits({1'b0, cfg.word_size_sel} + 5'h01),
        .miso(sin), .got(got), .got_cnt(got_cnt));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    // ****************************************
    // Watchers
    // ****************************************
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            chk("rx_data", exp_rx.size() ? exp_rx.pop_front() : 32'hDEAD, rx_data);
        if (pins.fss_o === 1'b0) len++;
        else if (len != 0) begin
            if (exp_len.size() == 0) chk("fss_rise", 0, 1);
            else if (exp_len[0] == 0) void'(exp_len.pop_front());
            else chk("fss_low_len", exp_len.pop_front(), len);
            len = 0;
        end
    end
    always @(got_cnt) if (got_cnt != 0)
        chk("slave_word", exp_tx.size() ? exp_tx.pop_front() : 32'hDEAD, got);
    initial begin
        #400000;
        chk("watchdog", 0, 1);
        close_out();
    end
    // ****************************************
    // Drivers
    // ****************************************
    task automatic send(input logic [15:0] d);
        int n;
        n = 0;
        tx_valid <= 1'b1;
        tx_data <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 4000);
        if (n >= 4000) chk("tx_taken", 1, 0);
        taken++;
    endtask : send
    task automatic setup(input logic [15:0] c);
        port_enable <= 1'b0;
        @(posedge sys_clk);
        cfg <= c;
        @(posedge sys_clk);
        port_enable <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("clk_idle", (c[5:4] == 2'h0) ? c[6] : 1'b0, pins.clk_o);
        chk("fss_idle", 1, pins.fss_o);
        chk("tx_idle", 0, pins.tx_o);
        chk("clk_oe", 1, pins.clk_oe);
        chk("fss_oe", 1, pins.fss_oe);
        chk("tx_oe", 1, pins.tx_oe);
        cfg <= c ^ 16'h0040;
        repeat (4) @(posedge sys_clk);
        chk("clk_held", (c[5:4] == 2'h0) ? c[6] : 1'b0, pins.clk_o);
        cfg <= c;
    endtask : setup
    initial begin
        logic [15:0] d;
        logic [15:0] r;
        int          w;
        int          h;
        int          b;
        seed = 17634;
        miscompares = 0;
        num_checks = 0;
        len = 0;
        rst_n = 1'b0;
        port_enable = 1'b0;
        slave_mode_sel = 1'b0;
        slave_out_disable = 1'b0;
        cfg = 16'h0000;
        pre = 8'h04;
        tx_valid = 1'b0;
        tx_data = 16'h0000;
        rx_ready = 1'b1;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk("fss_reset", 1, pins.fss_o);
        for (int i = 0; i < 6; i++) begin
            pre <= 8'(4 + 2 * (i % 2));
            setup(TCFG[i]);
            w = TCFG[i][3:0] + 1;
            h = (2 + i % 2) * (TCFG[i][15:8] + 1);
            b = (TCFG[i][5:4] == 2'h2) ? w + 9 : w;
            taken = 0;
            rx_ready <= (i != 4);
            for (int j = 0; j < NW[i]; j++) begin
                d = $random(seed);
                r = $random(seed);
                ssp_slave_model_inst.rq.push_back(r);
                exp_rx.push_back(r & (16'hFFFF >> (16 - w)));
                exp_tx.push_back(TCFG[i][5:4] == 2'h2 ? {8'h00, d[7:0]}
                                 : d & (16'hFFFF >> (16 - w)));
                if (TCFG[i][5:4] == 2'h0 && !TCFG[i][7])
                    exp_len.push_back((2 * w + 2) * h);
                else if (j == 0)
                    exp_len.push_back((2 * b * NW[i] + 2) * h);
                if (i == 4 && j == 2) fork
                    begin
                        repeat (300) @(posedge sys_clk);
                        chk("stall_taken", 2, taken);
                        chk("stall_rx_valid", 1, rx_valid);
                        rx_ready <= 1'b1;
                    end
                join_none
                send(d);
            end
            tx_valid <= 1'b0;
            for (int n = 0; n < 5000 && exp_rx.size() + exp_len.size() + exp_tx.size() != 0; n++)
                @(posedge sys_clk);
            chk("drained", 0, exp_rx.size() + exp_len.size() + exp_tx.size());
        end
        setup(16'h0017);
        tx_valid <= 1'b1;
        repeat (40) begin
            @(posedge sys_clk);
            chk("fmt1_ready", 0, tx_ready);
        end
        port_enable <= 1'b0;
        repeat (20) begin
            @(posedge sys_clk);
            chk("off_ready", 0, tx_ready);
        end
        tx_valid <= 1'b0;
        slave_mode_sel <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("slave_out_oe", 1, pins.tx_oe);
        slave_out_disable <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("slave_clk_oe", 0, pins.clk_oe);
        chk("slave_fss_oe", 0, pins.fss_oe);
        chk("slave_tx_oe", 0, pins.tx_oe);
        close_out();
    end
endmodule : tb_ssp_frames
